// File: design/dglog_logger.v
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "dglog_regs.vh"
module dglog_logger #(
	parameter NVAR  = 32,    // internal variable words
	parameter VIW   = 5,     // variable index width
	parameter MAXV  = 32,    // capture list entries
	parameter NTRIG = 4,     // trigger table entries
	parameter AW    = 15     // store address width
) (
	input  wire                 pclk,     // clock
	input  wire                 presetn,  // async reset, active low
	input  wire                 psel,     // apb select
	input  wire                 penable,  // apb enable
	input  wire                 pwrite,   // apb direction
	input  wire [7:0]           paddr,    // apb byte address
	input  wire [31:0]          pwdata,   // apb write data
	output reg  [31:0]          prdata,   // apb read data
	output wire                 pready,   // apb ready
	output wire                 pslverr,  // apb error
	input  wire                 cur_tick, // current loop tick pulse
	input  wire                 pos_tick, // position loop tick pulse
	input  wire [NVAR*16-1:0]   var_bus   // loop variable words
);
	localparam DEPTH = 1 << AW;
	reg  [15:0]       mem [0:DEPTH-1];
	reg  [VIW-1:0]    vlist_r [0:MAXV-1];
	reg  [15:0]       tcond_r [0:NTRIG-1];
	reg  [VIW-1:0]    tvar_r [0:NTRIG-1];
	reg  [31:0]       tconst_r [0:NTRIG-1];
	reg  [1:0]        st_r;
	reg  [2:0]        cap_r;
	reg  [3:0]        ntrig_r;
	reg  [6:0]        nvar_r;
	reg  [15:0]       delay_r, rate_r, count_r, rcnt_r, dcnt_r, left_r;
	reg               tbase_r, err_r, fired_r, busy_r, wrap_r, clr_r, eval_r;
	reg  [NVAR*16-1:0] snap_r;
	reg  [6:0]        wcnt_r;
	reg  [AW-1:0]     wr_r, rd_r;
	reg  [AW:0]       region_r, stored_r, rleft_r;
	reg  [NTRIG-1:0]  seq_r, stage;
	reg  [15:0]       ncost;
	reg               acc, go;
	integer           i, j;
	wire [NTRIG-1:0]  hit;
	function [15:0] vword;
		input [NVAR*16-1:0] bus;
		input [VIW-1:0]     idx;
		vword = bus[idx*16 +: 16];
	endfunction
	wire acc_ph = psel & penable;
	wire wr_en  = acc_ph & pwrite;
	wire known  = (paddr <= `DGLOG_REMAIN) && (paddr[1:0] == 2'h0);
	assign pready  = 1'b1;
	assign pslverr = acc_ph & ~known;
	wire        trig_on = (ntrig_r != 4'h0);
	wire        tb_tick = tbase_r ? cur_tick : pos_tick;
	wire        period  = tb_tick && (rcnt_r == rate_r);
	wire [15:0] mag     = delay_r[15] ? (16'h0 - delay_r) : delay_r;
	wire [15:0] wsg     = pwdata[15:0];
	wire [15:0] wmag    = wsg[15] ? (16'h0 - wsg) : wsg;
	genvar g;
	generate
		for (g = 0; g < NTRIG; g = g + 1) begin : trg
			dglog_trig u_trig (
				.pclk    (pclk),
				.presetn (presetn),
				.clr     (clr_r),
				.tick    (tb_tick),
				.cond    (tcond_r[g]),
				.konst   (tconst_r[g]),
				.val_lo  (vword(var_bus, tvar_r[g])),
				.val_hi  (vword(var_bus, tvar_r[g] + 1'b1)),
				.hit_r   (hit[g])
			);
		end
	endgenerate
	always @* begin
		acc = hit[0];
		go = 1'b1;
		stage = {NTRIG{1'b0}};
		stage[0] = hit[0];
		for (i = 1; i < NTRIG; i = i + 1) begin
			if (go && (i < ntrig_r)) begin
				case (tcond_r[i-1][`DGLOG_F_REL])
				`DGLOG_REL_AND: acc = acc & hit[i];
				`DGLOG_REL_OR:  acc = acc | hit[i];
				`DGLOG_REL_LAST: go = 1'b0;
				default:        acc = (seq_r[i-1] | stage[i-1]) & hit[i];
				endcase
			end
			stage[i] = acc;
		end
	end
	wire trig_ev = eval_r && trig_on && acc;
	// trigger words reduce the sample limit
	always @* begin
		ncost = `DGLOG_MAX_WORDS;
		for (j = 0; j < NTRIG; j = j + 1) begin
			if (j < ntrig_r)
				ncost = ncost - (tcond_r[j][`DGLOG_F_DBL] ? `DGLOG_DBL_COST
					: `DGLOG_SGL_COST);
		end
	end
	wire [15:0] max_smp = (nvar_r == 7'h0) ? 16'h0 : ncost / {9'h0, nvar_r};
	wire [AW+16:0] rwords = wsg * nvar_r;
	// words needed include one spare sample
	wire [AW+16:0] used = (count_r + 16'h1) * nvar_r;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r     <= `DGLOG_S_IDLE;
			ntrig_r  <= 4'h0;
			nvar_r   <= 7'h0;
			delay_r  <= 16'h0;
			rate_r   <= 16'h0;
			count_r  <= 16'h0;
			tbase_r  <= 1'b0;
			err_r    <= 1'b0;
			clr_r    <= 1'b0;
			region_r <= {(AW+1){1'b0}};
		end else begin
			clr_r <= 1'b0;
			if (wr_en) begin
				case (paddr)
				`DGLOG_CLEAR: begin
					ntrig_r <= 4'h0;
					nvar_r  <= 7'h0;
					st_r    <= `DGLOG_S_IDLE;
					err_r   <= 1'b0;
					clr_r   <= 1'b1;
				end
				`DGLOG_TCOND: begin
					if (st_r == `DGLOG_S_IDLE && ntrig_r < NTRIG
						&& !wsg[`DGLOG_F_RSVD]) begin
						tcond_r[ntrig_r[1:0]] <= wsg;
						st_r <= `DGLOG_S_TVAR;
					end else
						err_r <= 1'b1;
				end
				`DGLOG_VAR: begin
					// variable after a condition names the compared one
					if (st_r == `DGLOG_S_TVAR) begin
						tvar_r[ntrig_r[1:0]] <= pwdata[VIW-1:0];
						st_r <= `DGLOG_S_TCONST;
					end else if (st_r == `DGLOG_S_LIST && nvar_r < MAXV) begin
						// each listed word takes one store word
						vlist_r[nvar_r[4:0]] <= pwdata[VIW-1:0];
						nvar_r <= nvar_r + 7'h1;
					end else
						err_r <= 1'b1;
				end
				`DGLOG_TCONST: begin
					// constant only right after the variable
					if (st_r == `DGLOG_S_TCONST) begin
						tconst_r[ntrig_r[1:0]] <= pwdata;
						ntrig_r <= ntrig_r + 4'h1;
						st_r <= `DGLOG_S_IDLE;
					end else
						err_r <= 1'b1;
				end
				`DGLOG_DELAY: begin
					// negative only with a trigger, never -32768
					if (st_r == `DGLOG_S_IDLE && (!wsg[15] || (trig_on && wmag[15] == 1'b0)))
						delay_r <= wsg;
					else
						err_r <= 1'b1;
				end
				`DGLOG_RATE: begin
					if (st_r == `DGLOG_S_IDLE)
						rate_r <= wsg;
					else
						err_r <= 1'b1;
				end
				`DGLOG_SBEGIN: begin
					// only 0 or 1, table already complete
					if (st_r == `DGLOG_S_IDLE && pwdata[31:1] == 31'h0) begin
						tbase_r <= pwdata[0];
						nvar_r  <= 7'h0;
						st_r    <= `DGLOG_S_LIST;
					end else
						err_r <= 1'b1;
				end
				`DGLOG_SFINISH: begin
					// count within limit and covering the pre-trigger span
					if (st_r == `DGLOG_S_LIST && nvar_r != 7'h0 && !wsg[15]
						&& wsg <= max_smp && (!delay_r[15] || mag <= wsg)) begin
						count_r  <= wsg;
						region_r <= rwords[AW:0];
						st_r     <= `DGLOG_S_IDLE;
					end else
						err_r <= 1'b1;
				end
				default: ;
				endcase
			end
		end
	end
	wire arm = wr_en && paddr == `DGLOG_SFINISH && st_r == `DGLOG_S_LIST
		&& nvar_r != 7'h0 && !wsg[15] && wsg <= max_smp && (!delay_r[15] || mag <= wsg);
	wire stop = wr_en && (paddr == `DGLOG_CLEAR || paddr == `DGLOG_SBEGIN);
	wire take = period && !busy_r && (cap_r == `DGLOG_C_PRE || cap_r == `DGLOG_C_RUN
		&& left_r != 16'h0 || cap_r == `DGLOG_C_DELAY && dcnt_r == 16'h0);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap_r   <= `DGLOG_C_IDLE;
			rcnt_r  <= 16'h0;
			dcnt_r  <= 16'h0;
			left_r  <= 16'h0;
			fired_r <= 1'b0;
			eval_r  <= 1'b0;
			seq_r   <= {NTRIG{1'b0}};
		end else begin
			eval_r <= tb_tick;
			if (tb_tick)
				rcnt_r <= period ? 16'h0 : rcnt_r + 16'h1;
			// latch chained stages for become-true-then links
			if (eval_r)
				seq_r <= seq_r | stage;
			if (stop) begin
				cap_r <= `DGLOG_C_IDLE;
				seq_r <= {NTRIG{1'b0}};
			end else if (arm) begin
				fired_r <= 1'b0;
				rcnt_r  <= 16'h0;
				seq_r   <= {NTRIG{1'b0}};
				dcnt_r  <= delay_r;
				left_r  <= wsg;
				if (!trig_on)
					cap_r <= `DGLOG_C_DELAY;
				else if (delay_r[15])
					cap_r <= `DGLOG_C_PRE;
				else
					cap_r <= `DGLOG_C_WAITT;
			end else begin
				case (cap_r)
				`DGLOG_C_WAITT: begin
					// positive delay counts periods after the event
					if (trig_ev) begin
						fired_r <= 1'b1;
						cap_r   <= `DGLOG_C_DELAY;
					end
				end
				`DGLOG_C_DELAY: begin
					// delay periods pass before the first sample
					if (left_r == 16'h0)
						cap_r <= `DGLOG_C_DONE;
					else if (period && !busy_r) begin
						if (dcnt_r == 16'h0) begin
							left_r <= left_r - 16'h1;
							cap_r  <= `DGLOG_C_RUN;
						end else
							dcnt_r <= dcnt_r - 16'h1;
					end
				end
				`DGLOG_C_PRE: begin
					// ring keeps samples until the event
					if (trig_ev) begin
						fired_r <= 1'b1;
						left_r  <= left_r - mag;
						cap_r   <= `DGLOG_C_RUN;
					end
				end
				`DGLOG_C_RUN: begin
					if (take)
						left_r <= left_r - 16'h1;
					else if (left_r == 16'h0 && !busy_r)
						cap_r <= `DGLOG_C_DONE;
				end
				default: ;
				endcase
			end
		end
	end
	// snapshot writer and read-out
	wire rd_pop = acc_ph && !pwrite && paddr == `DGLOG_DATA && cap_r == `DGLOG_C_DONE
		&& rleft_r != {(AW+1){1'b0}};
	wire last_w = (wcnt_r + 7'h1 == nvar_r);
	wire [AW:0] wr_inc = {1'b0, wr_r} + 1'b1;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_r   <= 1'b0;
			wcnt_r   <= 7'h0;
			wr_r     <= {AW{1'b0}};
			rd_r     <= {AW{1'b0}};
			wrap_r   <= 1'b0;
			stored_r <= {(AW+1){1'b0}};
			rleft_r  <= {(AW+1){1'b0}};
			snap_r   <= {(NVAR*16){1'b0}};
		end else if (arm || stop) begin
			busy_r   <= 1'b0;
			wr_r     <= {AW{1'b0}};
			wrap_r   <= 1'b0;
			stored_r <= {(AW+1){1'b0}};
			rleft_r  <= {(AW+1){1'b0}};
		end else begin
			// whole snapshot is frozen at once so words stay coherent
			if (take) begin
				snap_r <= var_bus;
				busy_r <= 1'b1;
				wcnt_r <= 7'h0;
			end else if (busy_r) begin
				mem[wr_r] <= vword(snap_r, vlist_r[wcnt_r[4:0]]);
				wcnt_r <= wcnt_r + 7'h1;
				busy_r <= !last_w;
				if (stored_r != region_r)
					stored_r <= stored_r + 1'b1;
				if (wr_inc == region_r) begin
					wr_r   <= {AW{1'b0}};
					wrap_r <= 1'b1;
				end else
					wr_r <= wr_inc[AW-1:0];
			end
			// read-out opens only when capture is complete
			if (cap_r == `DGLOG_C_RUN && left_r == 16'h0 && !busy_r && !take) begin
				rd_r    <= wrap_r ? wr_r : {AW{1'b0}};
				rleft_r <= stored_r;
			end else if (rd_pop) begin
				rleft_r <= rleft_r - 1'b1;
				rd_r    <= ({1'b0, rd_r} + 1'b1 == region_r) ? {AW{1'b0}} : rd_r + 1'b1;
			end
		end
	end
	// read data captured in the setup phase
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0;
		else if (psel && !penable && !pwrite) begin
			case (paddr)
			`DGLOG_DELAY:   prdata <= {16'h0, delay_r};
			`DGLOG_RATE:    prdata <= {16'h0, rate_r};
			`DGLOG_SBEGIN:  prdata <= {31'h0, tbase_r};
			`DGLOG_SFINISH: prdata <= {16'h0, count_r};
			`DGLOG_STATUS:  prdata <= {used[15:0], err_r, fired_r, busy_r, cap_r,
				st_r, ntrig_r, nvar_r[3:0]};
			`DGLOG_DATA:    prdata <= (cap_r == `DGLOG_C_DONE && rleft_r != {(AW+1){1'b0}})
				? {16'h0, mem[rd_r]} : 32'h0;
			`DGLOG_REMAIN:  prdata <= {max_smp, 16'h0} | {{(31-AW){1'b0}}, rleft_r};
			default:        prdata <= 32'h0;
			endcase
		end
	end
endmodule

// File: design/dglog_regs.vh
`ifndef DGLOG_REGS_VH
`define DGLOG_REGS_VH
// apb byte offsets
`define DGLOG_CLEAR      8'h00
`define DGLOG_TCOND      8'h04
`define DGLOG_TCONST     8'h0C
`define DGLOG_DELAY      8'h10
`define DGLOG_RATE       8'h14
`define DGLOG_SBEGIN     8'h18
`define DGLOG_VAR        8'h1C
`define DGLOG_SFINISH    8'h20
`define DGLOG_STATUS     8'h24
`define DGLOG_DATA       8'h28
`define DGLOG_REMAIN     8'h2C
// condition word fields
`define DGLOG_F_RSVD     15
`define DGLOG_F_CMP      14:13
`define DGLOG_F_REL      12:11
`define DGLOG_F_SGN      10:9
`define DGLOG_F_DBL      8
`define DGLOG_F_WGT      7:0
`define DGLOG_CMP_LT     2'h0
`define DGLOG_CMP_GT     2'h1
`define DGLOG_CMP_FALL   2'h2
`define DGLOG_REL_LAST   2'h0
`define DGLOG_REL_AND    2'h1
`define DGLOG_REL_OR     2'h2
`define DGLOG_SGN_ABS    2'h2
`define DGLOG_SGN_BOTH   2'h3
`define DGLOG_WGT_ONE    10'h100
`define DGLOG_FRAC       8
// sample count limits
`define DGLOG_MAX_WORDS  16'h7FFF
`define DGLOG_SGL_COST   16'h0005
`define DGLOG_DBL_COST   16'h0007
// setup states
`define DGLOG_S_IDLE     2'h0
`define DGLOG_S_TVAR     2'h1
`define DGLOG_S_TCONST   2'h2
`define DGLOG_S_LIST     2'h3
// capture states
`define DGLOG_C_IDLE     3'h0
`define DGLOG_C_WAITT    3'h1
`define DGLOG_C_DELAY    3'h2
`define DGLOG_C_PRE      3'h3
`define DGLOG_C_RUN      3'h4
`define DGLOG_C_DONE     3'h5
`endif

// File: design/dglog_trig.v
`timescale 1ns/1ps
`include "dglog_regs.vh"
module dglog_trig (
	input  wire        pclk,    // clock
	input  wire        presetn, // async reset, active low
	input  wire        clr,     // empty filter state
	input  wire        tick,    // selected loop tick
	input  wire [15:0] cond,    // condition word
	input  wire [31:0] konst,   // trigger constant
	input  wire [15:0] val_lo,  // variable low word
	input  wire [15:0] val_hi,  // variable high word
	output reg         hit_r    // comparison result of last tick
);
	wire        dbl = cond[`DGLOG_F_DBL];
	wire [1:0]  sgn = cond[`DGLOG_F_SGN];
	wire        sv  = sgn[1];
	wire        sc  = (sgn == `DGLOG_SGN_BOTH);
	wire [31:0] raw = dbl ? {val_hi, val_lo} : {{16{sv & val_lo[15]}}, val_lo};
	wire [31:0] kr  = dbl ? konst : {{16{sc & konst[15]}}, konst[15:0]};
	wire signed [33:0] v = {{2{sv & raw[31]}}, raw};
	wire signed [33:0] c = {{2{sc & kr[31]}}, kr};
	wire signed [9:0]  w  = {2'h0, cond[`DGLOG_F_WGT]};
	wire signed [9:0]  wn = `DGLOG_WGT_ONE - w;
	reg  signed [41:0] filt_r;
	// fraction of the old value is kept in the low bits
	// weighted filter
	wire signed [51:0] p1 = v * w;
	wire signed [51:0] p2 = filt_r * wn;
	wire signed [51:0] p2s = p2 >>> `DGLOG_FRAC;
	wire signed [41:0] filt_nxt = p1[41:0] + p2s[41:0];
	wire signed [33:0] now_i = filt_nxt[41:8];
	wire signed [33:0] old_i = filt_r[41:8];
	// absolute value when signed against unsigned
	wire signed [33:0] now_v = (sgn == `DGLOG_SGN_ABS && now_i < 0) ? -now_i : now_i;
	wire signed [33:0] old_v = (sgn == `DGLOG_SGN_ABS && old_i < 0) ? -old_i : old_i;
	reg hit_nxt;
	// comparison kinds, crossings use the previous tick
	always @* begin
		case (cond[`DGLOG_F_CMP])
		`DGLOG_CMP_LT:   hit_nxt = now_v < c;
		`DGLOG_CMP_GT:   hit_nxt = now_v > c;
		`DGLOG_CMP_FALL: hit_nxt = (old_v >= c) && (now_v < c);
		default:         hit_nxt = (old_v <= c) && (now_v > c);
		endcase
	end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			filt_r <= 42'h0;
			hit_r  <= 1'b0;
		end else if (clr) begin
			filt_r <= 42'h0;
			hit_r  <= 1'b0;
		end else if (tick) begin
			filt_r <= filt_nxt;
			hit_r  <= hit_nxt;
		end
	end
endmodule

// File: verification/dglog_assertions.sv
`timescale 1ns/1ps
`include "dglog_regs.vh"
module dglog_logger_chk #(
	parameter NVAR = 32 // variable words
) (
	input logic               pclk,     // clock
	input logic               presetn,  // reset
	input logic               psel,     // select
	input logic               penable,  // enable
	input logic               pwrite,   // direction
	input logic [7:0]         paddr,    // address
	input logic [31:0]        pwdata,   // write data
	input logic [31:0]        prdata,   // read data
	input logic               pready,   // ready
	input logic               pslverr,  // error
	input logic               cur_tick, // current tick
	input logic               pos_tick, // position tick
	input logic [NVAR*16-1:0] var_bus   // variables
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence rd_setup(a);
		psel && !penable && !pwrite && paddr == a;
	endsequence
	sequence bad_access;
		psel && penable && (paddr > 8'h2C || paddr[1:0] != 2'h0);
	endsequence
	ready_high_a: assert property (pready)
		else $error("pready low");
	unmapped_err_a: assert property (bad_access |-> pslverr)
		else $error("unmapped access not flagged");
	mapped_ok_a: assert property (psel && penable && paddr <= 8'h2C && paddr[1:0] == 2'h0
		|-> !pslverr) else $error("mapped access flagged");
	err_idle_a: assert property (!(psel && penable) |-> !pslverr)
		else $error("error outside access");
	rdata_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("read data changed without read");
	sbegin_bit_a: assert property (rd_setup(`DGLOG_SBEGIN) |=> prdata[31:1] == 31'h0)
		else $error("timebase holds more than one bit");
	remain_max_a: assert property (rd_setup(`DGLOG_REMAIN) |=> !prdata[31])
		else $error("max samples above limit");
	status_state_a: assert property (rd_setup(`DGLOG_STATUS) |=> prdata[12:10] <= 3'h5)
		else $error("capture state out of range");
	status_words_a: assert property (rd_setup(`DGLOG_STATUS) |=> prdata[31:16] <= 16'h8000)
		else $error("words used above store size");
endmodule

// File: verification/dglog_loop_model.sv
`timescale 1ns/1ps
module dglog_loop_model #(
	parameter NVAR = 32, // variable words
	parameter TPER = 40  // clocks per current tick
) (
	input  logic               pclk,     // clock
	input  logic               presetn,  // reset
	output logic               cur_tick, // current tick
	output logic               pos_tick, // position tick
	output logic [NVAR*16-1:0] var_bus   // variables
);
	logic [7:0]  div_r;
	logic [11:0] cnt_r;
	// position loop runs at half the current loop rate
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r    <= 8'h00;
			cnt_r    <= 12'h000;
			cur_tick <= 1'b0;
			pos_tick <= 1'b0;
		end else begin
			cur_tick <= div_r == TPER - 1;
			pos_tick <= div_r == TPER - 1 && cnt_r[0];
			div_r    <= (div_r == TPER - 1) ? 8'h00 : div_r + 8'h01;
			if (div_r == TPER - 1)
				cnt_r <= cnt_r + 12'h001;
		end
	end
	// word k carries the low 4 bits of its index on top so the order of a snapshot is visible
	always_comb begin
		for (int k = 0; k < NVAR; k++)
			var_bus[16*k +: 16] = {4'(k), cnt_r};
	end
endmodule

// File: verification/test_dglog_logger.sv
`timescale 1ns/1ps
`include "dglog_regs.vh"
module test_dglog_logger;
	logic         pclk    = 1'b0;
	logic         presetn = 1'b0;
	logic         psel    = 1'b0;
	logic         penable = 1'b0;
	logic         pwrite  = 1'b0;
	logic [7:0]   paddr   = 8'h00;
	logic [31:0]  pwdata  = 32'h0;
	logic [31:0]  prdata;
	logic         pready;
	logic         pslverr;
	logic         cur_tick;
	logic         pos_tick;
	logic [511:0] var_bus;
	logic [31:0]  rd;
	logic         er;
	int           errors     = 0;
	int           num_checks = 0;
	logic [7:0]   ra [3] = '{`DGLOG_DELAY, `DGLOG_SBEGIN, `DGLOG_TCOND};
	logic [31:0]  rv [3] = '{32'h0000FFFF, 32'h00000002, 32'h00008000};
	always #2.5 pclk = ~pclk;
	dglog_logger i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cur_tick(cur_tick), .pos_tick(pos_tick), .var_bus(var_bus));
	dglog_loop_model i_loop (.pclk(pclk), .presetn(presetn), .cur_tick(cur_tick),
		.pos_tick(pos_tick), .var_bus(var_bus));
	task check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task get(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	task wait_done;
		for (int i = 0; i < 3000; i++) begin
			get(`DGLOG_STATUS);
			if (rd[12:10] === 3'h5) break;
		end
	endtask
	task run_cap(input logic sb, input logic [15:0] rate, input int nv);
		logic [11:0] prev;
		wr(`DGLOG_CLEAR, 32'h0);
		wr(`DGLOG_DELAY, 32'h1);
		wr(`DGLOG_RATE, {16'h0, rate});
		wr(`DGLOG_SBEGIN, {31'h0, sb});
		for (int v = 0; v < nv; v++) wr(`DGLOG_VAR, 32'(3 + v));
		wr(`DGLOG_SFINISH, 32'h4);
		get(`DGLOG_STATUS);
		check(rd[31:16], 32'(nv * 5));
		get(`DGLOG_REMAIN);
		check(rd[31:16], 32'(32767 / nv));
		wait_done;
		get(`DGLOG_REMAIN);
		check(rd[15:0], 32'(nv * 4));
		prev = 12'h000;
		for (int s = 0; s < 4; s++) begin
			for (int v = 0; v < nv; v++) begin
				get(`DGLOG_DATA);
				check(rd[15:12], 32'(3 + v));
				if (v == 0 && s > 0) check(rd[11:0] - prev, 32'((rate + 1) * (sb ? 1 : 2)));
				if (v == 0) prev = rd[11:0];
			end
		end
		get(`DGLOG_DATA);
		check(rd, 32'h0);
		$display("capture test done timebase %0d rate %0d", sb, rate);
	endtask
	task trig(input logic [1:0] cmp);
		logic [11:0] c;
		wr(`DGLOG_CLEAR, 32'h0);
		c = i_loop.cnt_r + 12'h014;
		// condition, variable, constant in a row
		wr(`DGLOG_TCOND, {17'h0, cmp, 2'h0, 2'h0, 1'b0, 8'hFF});
		wr(`DGLOG_VAR, 32'h0);
		wr(`DGLOG_TCONST, {20'h0, c});
		wr(`DGLOG_DELAY, 32'h0);
		wr(`DGLOG_RATE, 32'h0);
		wr(`DGLOG_SBEGIN, 32'h1);
		wr(`DGLOG_VAR, 32'h0);
		wr(`DGLOG_SFINISH, 32'h2);
		get(`DGLOG_REMAIN);
		check(rd[31:16], 32'h7FFA);
		get(`DGLOG_DATA);
		check(rd, 32'h0);
		get(`DGLOG_STATUS);
		check(rd[14], 1'b0);
		wait_done;
		check(rd[14], 1'b1);
		get(`DGLOG_DATA);
		check(rd[11:0] > c, 1'b1);
		$display("trigger test done compare %0d", cmp);
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		get(`DGLOG_STATUS);
		check(rd, 32'h0);
		get(`DGLOG_SBEGIN);
		check(rd, 32'h0);
		get(8'h30);
		check(er, 1'b1);
		get(8'h05);
		check(er, 1'b1);
		$display("reset test done");
		for (int i = 0; i < 3; i++) begin
			wr(ra[i], rv[i]);
			get(`DGLOG_STATUS);
			check(rd[15], 1'b1);
			wr(`DGLOG_CLEAR, 32'h0);
			get(`DGLOG_STATUS);
			check(rd[15], 1'b0);
		end
		$display("refusal test done");
		run_cap(1'b1, 16'h0002, 2);
		run_cap(1'b0, 16'h0000, 1);
		trig(2'h1);
		trig(2'h3);
		conclude;
	end
	initial begin
		repeat (60000) @(posedge pclk);
		errors++;
		$display("FAIL %0t watchdog expired", $time);
		conclude;
	end
endmodule
bind dglog_logger dglog_logger_chk #(.NVAR(NVAR)) i_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .cur_tick(cur_tick),
	.pos_tick(pos_tick), .var_bus(var_bus));
